// ===== src/rrbcc_map.svh
// constants of the receive channel control block: latch bank addresses,
// field positions, reset values and checker figures.
// assumes inclusion by bare name from the package and the top module.
`ifndef RRBCC_MAP_SVH
`define RRBCC_MAP_SVH

// latch bank addresses, three consecutive banks per channel
`define RRBCC_BANK_COUNT 12
`define RRBCC_BANKS_PER_CH 4'h3
`define RRBCC_STATIC_BANK_0 4'h0
`define RRBCC_STATIC_BANK_1 4'h1
`define RRBCC_DYNAMIC_BANK_2 4'h2
`define RRBCC_STATIC_BANK_3 4'h3
`define RRBCC_STATIC_BANK_4 4'h4
`define RRBCC_DYNAMIC_BANK_5 4'h5
`define RRBCC_STATIC_BANK_6 4'h6
`define RRBCC_STATIC_BANK_7 4'h7
`define RRBCC_DYNAMIC_BANK_8 4'h8
`define RRBCC_STATIC_BANK_9 4'h9
`define RRBCC_STATIC_BANK_10 4'ha
`define RRBCC_DYNAMIC_BANK_11 4'hb
// offset of the dynamic bank inside a channel group
`define RRBCC_DYN_OFS 4'h2

// dynamic bank field positions
`define RRBCC_F_PLL_POWER 0
`define RRBCC_F_CHK_SEL_LO 1
`define RRBCC_F_CHK_SEL_HI 2
`define RRBCC_F_RECLK_PRI 3
`define RRBCC_F_RECLK_SEC 4
`define RRBCC_F_TX_PRI 5
`define RRBCC_F_TX_SEC 6

// reset values of the banks
`define RRBCC_STATIC_RESET 7'h00
`define RRBCC_DYNAMIC_RESET 7'h00

// checker select code that enables pattern checking
`define RRBCC_CHK_ENABLE 2'h2

// checker figures
`define RRBCC_SEQ_LEN 9'h1ff
`define RRBCC_LFSR_SEED 9'h1ff
`define RRBCC_ABORT_LIMIT 16'sh0010
`define RRBCC_DIFF_FLOOR -16'sh7fff

// status triple {status, data0, data1} codes
`define RRBCC_ST_MATCH 3'h0
`define RRBCC_ST_ERROR 3'h1
`define RRBCC_ST_WAIT 3'h7
`define RRBCC_ST_LOOP_CLEAN 3'h4
`define RRBCC_ST_LOOP_DIRTY 3'h2

`endif

// ===== src/rrbcc_pkg.sv
// types of the receive channel control block.
// assumes rrbcc_map.svh is on the include path.
`include "rrbcc_map.svh"

package rrbcc_pkg;

	// one word leaving a receive channel
	typedef struct packed {
		logic status;
		logic [9:0] char;
	} rrbcc_word_s;

	// decoded dynamic latch bank of one channel
	typedef struct packed {
		logic tx_sec;
		logic tx_pri;
		logic reclk_sec;
		logic reclk_pri;
		logic [1:0] chk_sel;
		logic pll_power;
	} rrbcc_dyn_s;

	// checker state machine
	typedef enum logic [1:0] {
		CHK_OFF,
		CHK_START,
		CHK_RUN
	} rrbcc_chk_e;

endpackage

// ===== src/rrbcc_top.sv
// receive channel control: configuration latches, power and driver
// enables, reclocker retiming path and receive pattern checker.
// assumes clk is the recovered character clock, deserialized characters,
// lock status and serial bits arrive on clk; the config pins are asynchronous.
`timescale 1ns/100ps
`include "rrbcc_map.svh"

module rrbcc_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// configuration pins, asynchronous
	input wire logic cfg_write_strobe_n,
	input wire logic [3:0] cfg_addr,
	input wire logic [7:0] cfg_data,
	// receive side from deserializer and cdr
	input wire logic [1:0] rx_pll_locked,
	input wire logic [1:0][9:0] rx_char_in,
	input wire logic [1:0] rx_char_valid,
	output logic [1:0] rx_char_ready,
	input wire logic [1:0] rx_serial_bit,
	// parallel output towards the user
	output rrbcc_pkg::rrbcc_word_s [1:0] rx_word,
	output logic [1:0] rx_word_valid,
	input wire logic [1:0] rx_word_ready,
	// reclocker serial outputs and driver enables
	output logic [1:0] reclk_primary_out,
	output logic [1:0] reclk_secondary_out,
	output logic [1:0] reclk_primary_driver_enable,
	output logic [1:0] reclk_secondary_driver_enable,
	output logic [1:0] reclk_logic_power,
	// transmit driver enables and power
	output logic [1:0] tx_primary_driver_enable,
	output logic [1:0] tx_secondary_driver_enable,
	output logic [1:0] tx_logic_power,
	// receive power and static banks
	output logic [1:0] rx_pll_power_on,
	output logic [7:0][6:0] static_latches
);
	import rrbcc_pkg::*;

	// next lfsr state, polynomial x^9 + x^5 + 1, period 511
	function automatic logic [8:0] lfsr_next(input logic [8:0] s);
		lfsr_next = {s[7:0], s[8] ^ s[4]};
	endfunction

	// expected character from the lfsr state
	function automatic logic [9:0] exp_char(input logic [8:0] s);
		exp_char = {s, ^s};
	endfunction

	// ------------------------------------------------------------------
	// configuration pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] strobe_sync; // three stages of the write strobe
	logic [2:0][3:0] addr_sync; // three stages of the address
	logic [2:0][7:0] data_sync; // three stages of the data
	logic strobe_level; // filtered strobe level
	logic bank_write; // one-cycle write of a bank

	// shift the pins through three flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strobe_sync <= 3'h7;
			addr_sync <= '0;
			data_sync <= '0;
		end else begin
			strobe_sync <= {strobe_sync[1:0], cfg_write_strobe_n};
			addr_sync <= {addr_sync[1:0], cfg_addr};
			data_sync <= {data_sync[1:0], cfg_data};
		end
	end

	// strobe level changes only when stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strobe_level <= 1'b1;
		end else if (strobe_sync[1] == strobe_sync[2]) begin
			strobe_level <= strobe_sync[2];
		end
	end

	// one write per falling strobe, held address and data taken
	assign bank_write = strobe_level && (strobe_sync[1] == strobe_sync[2]) &&
		!strobe_sync[2];

	// ------------------------------------------------------------------
	// latch banks, write only
	// ------------------------------------------------------------------
	logic [6:0] bank [0:`RRBCC_BANK_COUNT-1];
	logic [3:0] wr_addr; // address of the write
	logic [7:0] wr_data; // data of the write

	assign wr_addr = addr_sync[2];
	assign wr_data = data_sync[2];

	// store the low seven data bits into the addressed bank
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `RRBCC_BANK_COUNT; i++) begin
				bank[i] <= `RRBCC_STATIC_RESET;
			end
			bank[`RRBCC_DYNAMIC_BANK_2] <= `RRBCC_DYNAMIC_RESET;
			bank[`RRBCC_DYNAMIC_BANK_5] <= `RRBCC_DYNAMIC_RESET;
			bank[`RRBCC_DYNAMIC_BANK_8] <= `RRBCC_DYNAMIC_RESET;
			bank[`RRBCC_DYNAMIC_BANK_11] <= `RRBCC_DYNAMIC_RESET;
		end else if (bank_write && wr_addr <= `RRBCC_DYNAMIC_BANK_11) begin
			bank[wr_addr] <= wr_data[6:0];
		end
	end

	// static banks go out as raw settings, two per channel group
	assign static_latches[0] = bank[`RRBCC_STATIC_BANK_0];
	assign static_latches[1] = bank[`RRBCC_STATIC_BANK_1];
	assign static_latches[2] = bank[`RRBCC_STATIC_BANK_3];
	assign static_latches[3] = bank[`RRBCC_STATIC_BANK_4];
	assign static_latches[4] = bank[`RRBCC_STATIC_BANK_6];
	assign static_latches[5] = bank[`RRBCC_STATIC_BANK_7];
	assign static_latches[6] = bank[`RRBCC_STATIC_BANK_9];
	assign static_latches[7] = bank[`RRBCC_STATIC_BANK_10];

	// ------------------------------------------------------------------
	// per channel logic, channel 0 owns banks 0 to 2
	// ------------------------------------------------------------------
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		localparam logic [3:0] DYN_ADDR = 4'(ch * 3) + `RRBCC_DYN_OFS;

		rrbcc_dyn_s dyn; // decoded dynamic bank
		logic chk_on; // checker selected
		logic reclk_on; // reclocker powered
		logic retimed; // retimed serial bit
		logic reclk_reg; // reclocker output register
		rrbcc_chk_e state; // checker state
		logic [8:0] lfsr; // expected sequence state
		logic [8:0] pos; // position in the loop
		logic signed [15:0] diff; // errors minus matches
		logic loop_err; // an error seen this loop
		logic accept; // character taken this cycle
		logic [9:0] expect_c; // expected character
		logic hit; // received equals expected
		logic signed [15:0] next_diff; // count after this character
		logic [2:0] triple; // status, data0, data1
		rrbcc_word_s in_word; // word entering the buffer
		rrbcc_word_s buf_mem [0:1]; // two-entry buffer storage
		logic wr_ptr; // buffer write index
		logic rd_ptr; // buffer read index
		logic [1:0] fill; // words held
		logic push; // buffer write
		logic pop; // buffer read

		assign dyn = bank[DYN_ADDR];

		// driver enables straight from latches, cleared by reset
		assign reclk_primary_driver_enable[ch] = dyn.reclk_pri;
		assign reclk_secondary_driver_enable[ch] = dyn.reclk_sec;
		assign tx_primary_driver_enable[ch] = dyn.tx_pri;
		assign tx_secondary_driver_enable[ch] = dyn.tx_sec;
		// either driver keeps the associated logic powered
		assign reclk_on = dyn.reclk_pri | dyn.reclk_sec;
		assign reclk_logic_power[ch] = reclk_on;
		assign tx_logic_power[ch] = dyn.tx_pri | dyn.tx_sec;
		assign rx_pll_power_on[ch] = dyn.pll_power;
		assign chk_on = dyn.chk_sel == `RRBCC_CHK_ENABLE;

		// --------------------------------------------------------------
		// reclocker path: retime, then output register
		// --------------------------------------------------------------
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				retimed <= 1'b0;
				reclk_reg <= 1'b0;
			end else if (reclk_on) begin
				retimed <= rx_serial_bit[ch];
				reclk_reg <= retimed;
			end else begin
				// powered down, both path registers are cleared to zero
				retimed <= 1'b0;
				reclk_reg <= 1'b0;
			end
		end

		// drivers pass the output register only while enabled
		assign reclk_primary_out[ch] = reclk_reg & dyn.reclk_pri;
		assign reclk_secondary_out[ch] = reclk_reg & dyn.reclk_sec;

		// --------------------------------------------------------------
		// pattern checker
		// --------------------------------------------------------------
		assign accept = rx_char_valid[ch] & rx_char_ready[ch];
		assign expect_c = exp_char(lfsr);
		assign hit = rx_char_in[ch] == expect_c;

		// running difference, floored so long clean runs cannot wrap
		always_comb begin
			next_diff = diff;
			if (hit) begin
				if (diff > `RRBCC_DIFF_FLOOR) begin
					next_diff = diff - 16'sh0001;
				end
			end else begin
				next_diff = diff + 16'sh0001;
			end
		end

		// checker state machine
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				state <= CHK_OFF;
			end else if (!chk_on) begin
				state <= CHK_OFF;
			end else if (!rx_pll_locked[ch]) begin
				state <= CHK_START;
			end else if (accept) begin
				unique case (state)
					CHK_OFF: begin
						state <= CHK_START;
					end
					CHK_START: begin
						// first character of the sequence found
						if (hit) begin
							state <= CHK_RUN;
						end
					end
					CHK_RUN: begin
						if (next_diff > `RRBCC_ABORT_LIMIT) begin
							state <= CHK_START;
						end
					end
				endcase
			end
		end

		// lfsr, loop position and counters
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				lfsr <= `RRBCC_LFSR_SEED;
				pos <= '0;
				diff <= '0;
				loop_err <= 1'b0;
			end else if (!chk_on || !rx_pll_locked[ch] || state == CHK_OFF) begin
				lfsr <= `RRBCC_LFSR_SEED;
				pos <= '0;
				diff <= '0;
				loop_err <= 1'b0;
			end else if (accept) begin
				if (state == CHK_START) begin
					// hold the seed until the first character matches
					if (hit) begin
						lfsr <= lfsr_next(lfsr);
						pos <= 9'h001;
					end
					diff <= '0;
					loop_err <= 1'b0;
				end else if (next_diff > `RRBCC_ABORT_LIMIT) begin
					lfsr <= `RRBCC_LFSR_SEED;
					pos <= '0;
					diff <= '0;
					loop_err <= 1'b0;
				end else begin
					lfsr <= lfsr_next(lfsr);
					diff <= next_diff;
					if (pos == `RRBCC_SEQ_LEN - 9'h001) begin
						pos <= '0;
						loop_err <= 1'b0;
					end else begin
						pos <= pos + 9'h001;
						loop_err <= loop_err | ~hit;
					end
				end
			end
		end

		// status triple of the character being taken
		always_comb begin
			triple = `RRBCC_ST_WAIT;
			if (state == CHK_RUN && rx_pll_locked[ch]) begin
				if (pos == `RRBCC_SEQ_LEN - 9'h001) begin
					// last character of a loop, one character only
					triple = (loop_err | ~hit) ? `RRBCC_ST_LOOP_DIRTY :
						`RRBCC_ST_LOOP_CLEAN;
				end else if (hit) begin
					triple = `RRBCC_ST_MATCH;
				end else begin
					triple = `RRBCC_ST_ERROR;
				end
			end else if (state == CHK_START && rx_pll_locked[ch] && hit) begin
				triple = `RRBCC_ST_MATCH;
			end
		end

		// word into the buffer: raw character, status fields when checking
		always_comb begin
			in_word.char = rx_char_in[ch];
			in_word.status = 1'b0;
			if (chk_on) begin
				in_word.status = triple[2];
				in_word.char[0] = triple[1];
				in_word.char[1] = triple[0];
			end
		end

		// --------------------------------------------------------------
		// two-entry buffer towards the parallel output
		// --------------------------------------------------------------
		assign rx_char_ready[ch] = fill != 2'h2;
		assign rx_word_valid[ch] = fill != 2'h0;
		assign push = accept;
		assign pop = rx_word_valid[ch] & rx_word_ready[ch];
		assign rx_word[ch] = buf_mem[rd_ptr];

		// buffer storage
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				buf_mem[0] <= '0;
				buf_mem[1] <= '0;
			end else if (push) begin
				buf_mem[wr_ptr] <= in_word;
			end
		end

		// buffer pointers and fill level
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				wr_ptr <= 1'b0;
				rd_ptr <= 1'b0;
				fill <= 2'h0;
			end else begin
				if (push) begin
					wr_ptr <= ~wr_ptr;
				end
				if (pop) begin
					rd_ptr <= ~rd_ptr;
				end
				if (push && !pop) begin
					fill <= fill + 2'h1;
				end else if (pop && !push) begin
					fill <= fill - 2'h1;
				end
			end
		end
	end

endmodule

// ===== bench/rrbcc_top_monitor.sv
// checker for the receive channel control block.
// assumes it is bound to rrbcc_top and sees only its ports.
`timescale 1ns/100ps
module rrbcc_top_mon (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// config strobe and character streams
	input wire logic cfg_write_strobe_n,
	input wire logic [1:0] rx_char_valid,
	input wire logic [1:0] rx_char_ready,
	input wire rrbcc_pkg::rrbcc_word_s [1:0] rx_word,
	input wire logic [1:0] rx_word_valid,
	input wire logic [1:0] rx_word_ready,
	// serial drivers and power
	input wire logic [1:0] reclk_primary_out,
	input wire logic [1:0] reclk_secondary_out,
	input wire logic [1:0] reclk_primary_driver_enable,
	input wire logic [1:0] reclk_secondary_driver_enable,
	input wire logic [1:0] reclk_logic_power,
	input wire logic [1:0] tx_primary_driver_enable,
	input wire logic [1:0] tx_secondary_driver_enable,
	input wire logic [1:0] tx_logic_power,
	input wire logic [1:0] rx_pll_power_on
);
	import rrbcc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// reclocker logic powered while either driver is on
	reclk_power_a: assert property (
		reclk_logic_power == (reclk_primary_driver_enable | reclk_secondary_driver_enable))
		else $error("reclocker power does not follow driver enables");
	// transmit logic powered while either driver is on
	tx_power_a: assert property (
		tx_logic_power == (tx_primary_driver_enable | tx_secondary_driver_enable))
		else $error("transmit power does not follow driver enables");
	// a disabled reclock driver stays quiet
	reclk_gate_a: assert property (
		((reclk_primary_out & ~reclk_primary_driver_enable) |
		(reclk_secondary_out & ~reclk_secondary_driver_enable)) == 2'b00)
		else $error("disabled reclock driver toggles");
	// reset sampled low turns every driver off
	reset_off_a: assert property (disable iff (1'b0) !arst_n |-> (
		reclk_primary_driver_enable | reclk_secondary_driver_enable | reclk_primary_out |
		tx_primary_driver_enable | tx_secondary_driver_enable) == 2'b00)
		else $error("driver enabled during reset");
	// pll power latch outputs move only after a strobe low period
	cfg_change_a: assert property ($changed(rx_pll_power_on) |->
		!($past(cfg_write_strobe_n, 2) && $past(cfg_write_strobe_n, 3) &&
		$past(cfg_write_strobe_n, 4) && $past(cfg_write_strobe_n, 5)))
		else $error("latch changed without a write");
	// an offered word holds until taken
	word_hold_a: assert property (rx_word_valid[0] && !rx_word_ready[0] |=>
		rx_word_valid[0] && $stable(rx_word[0]))
		else $error("output word dropped or changed while stalled");
	// an accepted character is offered one cycle later
	char_accept_a: assert property (
		rx_char_valid[0] && rx_char_ready[0] |=> rx_word_valid[0])
		else $error("accepted character not offered");
	// refusal only while words are held
	full_refuse_a: assert property (!rx_char_ready[0] |-> rx_word_valid[0])
		else $error("input refused while buffer empty");
	// main scenarios
	cover property (rx_word_valid[0] && rx_word_ready[0] && rx_word[0].status &&
		!rx_word[0].char[0]);
	cover property (!rx_char_ready[0]);
	cover property ($rose(reclk_logic_power[0]));
endmodule

bind rrbcc_top rrbcc_top_mon i_mon (.clk, .arst_n, .cfg_write_strobe_n, .rx_char_valid,
	.rx_char_ready, .rx_word, .rx_word_valid, .rx_word_ready, .reclk_primary_out,
	.reclk_secondary_out, .reclk_primary_driver_enable, .reclk_secondary_driver_enable,
	.reclk_logic_power, .tx_primary_driver_enable, .tx_secondary_driver_enable,
	.tx_logic_power, .rx_pll_power_on);

// ===== bench/rrbcc_remote_tx.sv
// remote serial transmitter model: offers the 511-character test
// sequence, stalls and corrupts characters when the bench asks.
// assumes transfers on valid and ready at the rising clock edge.
`timescale 1ns/100ps
module rrbcc_remote_tx (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// commands from the bench
	input wire logic locked,
	input wire logic stall,
	input wire logic corrupt,
	// character stream towards the receiver
	output logic [9:0] data,
	output logic valid,
	input wire logic ready,
	output logic [8:0] pos,
	output logic bad,
	output logic serial_bit
);
	logic [8:0] seq; // generator register
	logic [8:0] line; // free running serial source
	logic idle; // offer withheld
	assign valid = locked && !idle;
	assign data = bad ? 10'h000 : {seq, ^seq};
	assign serial_bit = line[8];
	// offer held until taken, then next character
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq <= 9'h1ff;
			pos <= 9'h000;
			line <= 9'h0a5;
			idle <= 1'b1;
			bad <= 1'b0;
		end else begin
			line <= {line[7:0], line[8] ^ line[4]};
			if (!valid || ready) begin
				idle <= stall;
				bad <= corrupt;
			end
			if (valid && ready) begin
				seq <= {seq[7:0], seq[8] ^ seq[4]};
				pos <= (pos == 9'd510) ? 9'h000 : pos + 9'h001;
			end
		end
	end
endmodule

// ===== bench/rrbcc_top_tb.sv
// self-checking bench for the receive channel control block.
// assumes the design, its package and the remote transmitter model.
`timescale 1ns/100ps
module rrbcc_top_tb;
	import rrbcc_pkg::*;
	logic clk = 0;
	logic arst_n = 1;
	logic cfg_write_strobe_n = 1;
	logic [3:0] cfg_addr = 0;
	logic [7:0] cfg_data = 0;
	logic [1:0] rx_pll_locked = 0, rx_word_ready = 0, stall = 0, corrupt = 0;
	wire [1:0][9:0] rx_char_in;
	wire [1:0][8:0] pos;
	wire [1:0] rx_char_valid, rx_serial_bit, bad;
	logic [1:0] rx_char_ready, rx_word_valid, reclk_primary_out, reclk_secondary_out;
	logic [1:0] reclk_primary_driver_enable, reclk_secondary_driver_enable;
	logic [1:0] reclk_logic_power, tx_logic_power, rx_pll_power_on;
	logic [1:0] tx_primary_driver_enable, tx_secondary_driver_enable;
	rrbcc_word_s [1:0] rx_word;
	logic [7:0][6:0] static_latches, sl;
	int n_errors = 0;
	int num_checks = 0;
	int seed = 32'h8323637f;
	logic [21:0] q [2][$]; // expected words, mask above value
	bit sync [2]; // checker model locked onto the sequence
	bit dirty [2];
	int net [2]; // errors minus matches
	int skip [2];
	bit chk_on [2] = '{1, 0};
	logic [1:0] h1, h2;
	logic [31:0] r;
	logic [7:0] d;
	logic rc_on = 0;
	logic sink_stop = 0;
	int c;
	always #5 clk = ~clk;
	rrbcc_top i_dut (.clk, .arst_n, .cfg_write_strobe_n, .cfg_addr, .cfg_data, .rx_pll_locked,
		.rx_char_in, .rx_char_valid, .rx_char_ready, .rx_serial_bit, .rx_word, .rx_word_valid,
		.rx_word_ready, .reclk_primary_out, .reclk_secondary_out, .reclk_primary_driver_enable,
		.reclk_secondary_driver_enable, .reclk_logic_power, .tx_primary_driver_enable,
		.tx_secondary_driver_enable, .tx_logic_power, .rx_pll_power_on, .static_latches);
	// one remote transmitter per channel
	for (genvar g = 0; g < 2; g++) begin : g_tx
		rrbcc_remote_tx i_tx (.clk, .arst_n, .locked(rx_pll_locked[g]), .stall(stall[g]),
			.corrupt(corrupt[g]), .data(rx_char_in[g]), .valid(rx_char_valid[g]),
			.ready(rx_char_ready[g]), .pos(pos[g]), .bad(bad[g]), .serial_bit(rx_serial_bit[g]));
	end
	task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// one latch bank write, strobe low four cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		cfg_addr = a;
		cfg_data = v;
		repeat (3) @(posedge clk);
		#1 cfg_write_strobe_n = 0;
		repeat (4) @(posedge clk);
		#1 cfg_write_strobe_n = 1;
		repeat (5) @(posedge clk);
		#1;
	endtask
	// wait until the transmitter offers position p
	task automatic till(input logic [8:0] p);
		for (int k = 0; k < 4000 && pos[0] != p; k++) begin
			@(posedge clk);
			#1;
		end
		check("till", pos[0], p);
	endtask
	// expected word carrying a status triple
	function automatic logic [21:0] mk(input logic [2:0] t);
		return {11'h403, t[2], 8'h00, t[0], t[1]};
	endfunction
	// checker model for one accepted character
	task automatic note(input int k);
		if (!chk_on[k]) q[k].push_back({11'h7ff, 1'b0, rx_char_in[k]});
		else if (skip[k] > 0) begin
			skip[k]--;
			q[k].push_back(22'h0);
		end else if (!sync[k]) begin
			sync[k] = (rx_char_in[k] == {`RRBCC_LFSR_SEED, ^`RRBCC_LFSR_SEED});
			net[k] = 0;
			dirty[k] = 0;
			q[k].push_back(mk(sync[k] ? 3'b000 : 3'b111));
		end else begin
			net[k] += bad[k] ? 1 : -1;
			if (net[k] > 16) begin
				sync[k] = 0;
				skip[k] = 1;
				q[k].push_back(22'h0);
			end else if (pos[k] == 9'd510) begin
				q[k].push_back(mk((dirty[k] | bad[k]) ? 3'b010 : 3'b100));
				dirty[k] = 0;
			end else begin
				dirty[k] |= bad[k];
				q[k].push_back(mk(bad[k] ? 3'b001 : 3'b000));
			end
		end
	endtask
	// input side notes, output side compares
	always @(posedge clk) begin
		logic [21:0] e;
		for (int k = 0; k < 2; k++) begin
			if (!rx_pll_locked[k]) sync[k] = 0;
			if (arst_n && rx_char_valid[k] && rx_char_ready[k]) note(k);
			if (arst_n && rx_word_valid[k] && rx_word_ready[k]) begin
				e = (q[k].size() > 0) ? q[k].pop_front() : 22'h3ff800;
				check("rx_word", rx_word[k] & e[21:11], e[10:0] & e[21:11]);
			end
		end
	end
	// random stalls and reclock comparison
	always @(posedge clk) begin
		#1;
		r = $random(seed);
		rx_word_ready = sink_stop ? 2'b00 : r[1:0] | r[3:2];
		stall = r[5:4] & r[7:6];
		if (rc_on) check("reclk_out", {reclk_secondary_out, reclk_primary_out},
			{h2[1], 2'b00, h2[0]});
		h2 = h1;
		h1 = rx_serial_bit;
	end
	initial begin
		#(10 * 40000);
		n_errors++;
		report_and_stop();
	end
	initial begin
		#1 arst_n = 0;
		repeat (4) @(posedge clk);
		#1 arst_n = 1;
		check("reset", {reclk_primary_driver_enable, reclk_secondary_driver_enable,
			tx_primary_driver_enable, tx_secondary_driver_enable, rx_pll_power_on,
			reclk_primary_out, static_latches}, 0);
		// every address, unmapped ones must not alias
		for (int a = 0; a < 16; a++) begin
			d = 8'($random(seed));
			wr(4'(a), d);
			if (a < 12 && a % 3 != 2) sl[a - a / 3] = d[6:0];
		end
		check("static_latches", static_latches, sl);
		// dynamic banks, far banks stored only
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			c = i % 2;
			wr(4'(3 * c + 2), d);
			wr(4'(3 * c + 8), ~d);
			check("dynamic", {rx_pll_power_on[c], reclk_primary_driver_enable[c],
				reclk_secondary_driver_enable[c], tx_primary_driver_enable[c],
				tx_secondary_driver_enable[c]}, {d[0], d[3], d[4], d[5], d[6]});
		end
		@(posedge clk);
		#1 arst_n = 0;
		#1 check("mid reset", {reclk_primary_driver_enable, tx_primary_driver_enable,
			tx_secondary_driver_enable, reclk_secondary_driver_enable}, 0);
		@(posedge clk);
		#1 arst_n = 1;
		check("static_latches", static_latches, 0);
		wr(`RRBCC_DYNAMIC_BANK_2, 8'h0d);
		wr(`RRBCC_DYNAMIC_BANK_5, 8'h11);
		rc_on <= 1;
		repeat (30) @(posedge clk);
		#1 rc_on <= 0;
		rx_pll_locked = 2'b11;
		till(9'd100);
		till(9'd0);
		till(9'd100);
		corrupt[0] = 1;
		till(9'd103);
		corrupt[0] = 0;
		sink_stop = 1;
		repeat (12) @(posedge clk);
		#1 check("rx_char_ready", rx_char_ready, 2'b00);
		sink_stop = 0;
		till(9'd0);
		till(9'd50);
		rx_pll_locked[0] = 0;
		repeat (2) @(posedge clk);
		#1 rx_pll_locked[0] = 1;
		till(9'd1);
		corrupt[0] = 1;
		till(9'd21);
		corrupt[0] = 0;
		till(9'd0);
		till(9'd30);
		rx_pll_locked = 2'b00;
		repeat (20) @(posedge clk);
		#1 check("pending", q[0].size() + q[1].size(), 0);
		report_and_stop();
	end
endmodule
